/* File: rtl/mmce_defs.svh */
// constants for the move, multiply and call decode block
`ifndef MMCE_DEFS_SVH
`define MMCE_DEFS_SVH
`define MMCE_OPC_CALL_HI 8'hb7
`define MMCE_OPC_BANK_HI 8'hb8
`define MMCE_OPC_LMUL_HI 8'hbc
`define MMCE_OPC_RMUL_HI 8'h34
`define MMCE_OPC_MOVE_TOP 3'h3
`define MMCE_ADDR_ACC 8'h0a
`define MMCE_ADDR_CLATCH 8'h03
`define MMCE_ADDR_BANK 8'h0f
`define MMCE_ADDR_PRODUCT_LOW_BYTE 8'h18
`define MMCE_ADDR_PRODUCT_HIGH_BYTE 8'h19
`define MMCE_Q_LAST 2'h3
`endif

/* File: rtl/mmce_pkg.sv */
// types for the move, multiply and call decode block
package mmce_pkg;
    typedef enum logic [2:0] {
        MMCE_OP_NONE,
        MMCE_OP_CALL,
        MMCE_OP_MOVE,
        MMCE_OP_BANK,
        MMCE_OP_LMUL,
        MMCE_OP_RMUL
    } mmce_op_t;
endpackage : mmce_pkg

/* File: rtl/mmce_if.sv */
// decoded fields passed from decoder to executor
`timescale 1ns/10ps
interface mmce_dec_if;
    mmce_pkg::mmce_op_t op;
    logic [7:0] lit;
    logic [7:0] faddr;
    logic [4:0] paddr;
    logic flag_inhibit;
    modport dec (output op, lit, faddr, paddr, flag_inhibit);
    modport exe (input op, lit, faddr, paddr, flag_inhibit);
endinterface : mmce_dec_if

/* File: rtl/mmce_decode.sv */
// instruction word decoder
`timescale 1ns/10ps
`include "mmce_defs.svh"
module mmce_decode (
    input wire logic [15:0] instr,
    mmce_dec_if.dec d
);
    function automatic mmce_pkg::mmce_op_t classify(input logic [15:0] w);
        if (w[15:13] == `MMCE_OPC_MOVE_TOP)
            return mmce_pkg::MMCE_OP_MOVE; // [RULE5]
        case (w[15:8])
            `MMCE_OPC_CALL_HI: return mmce_pkg::MMCE_OP_CALL;
            `MMCE_OPC_BANK_HI: return mmce_pkg::MMCE_OP_BANK; // [RULE9]
            `MMCE_OPC_LMUL_HI: return mmce_pkg::MMCE_OP_LMUL; // [RULE11]
            `MMCE_OPC_RMUL_HI: return mmce_pkg::MMCE_OP_RMUL; // [RULE13]
            default: return mmce_pkg::MMCE_OP_NONE;
        endcase
    endfunction : classify

    always_comb
    begin
        d.op = classify(instr);
        d.lit = instr[7:0]; // [RULE11]
        d.faddr = instr[7:0]; // [RULE5] [RULE13]
        d.paddr = instr[12:8]; // [RULE5]
        // multiplies never touch flags, zero product included
        d.flag_inhibit = (d.op == mmce_pkg::MMCE_OP_LMUL) ||
                         (d.op == mmce_pkg::MMCE_OP_RMUL); // [RULE15]
    end
endmodule : mmce_decode

/* File: rtl/mmce_exec.sv */
// execute logic for long call, file move, bank load and multiplies
// Notes on behaviour
// RULE1 - a long call loads the counter high byte from the holding latch and the low byte from the literal.
// RULE2 - a long call takes two cycles, the second being a forced no-operation flushing the fetched word.
// RULE3 - a long call first pushes the counter plus one onto the stack.
// RULE4 - the file move copies file address f (0..255) into destination p (0..31).
// RULE5 - the file move is opcode top bits 011, p in the next five bits, f in the low byte.
// RULE6 - either operand of the file move may be the working accumulator.
// RULE7 - the file move reads f in Q2 and writes p in Q4 of one cycle and leaves flags alone (file_we to p pulses in the next cycle's Q1).
// RULE8 - the bank load writes a 4-bit literal into bank select bits 3:0, keeping the upper nibble.
// RULE9 - the bank load is upper byte 1011 1000 with bits 7:4 ignored and one cycle long.
// RULE10 - the literal multiply writes literal times accumulator as 16 bits, high byte in product high.
// RULE11 - the literal multiply is upper byte 1011 1100 with the literal in the low byte.
// RULE12 - the register multiply writes accumulator times file f to the product pair, operands kept.
// RULE13 - the register multiply is upper byte 0011 0100 with f in the low byte.
// RULE14 - both multiplies write the product pair in Q4 so the next instruction sees it.
// RULE15 - multiplies raise no carry, overflow or zero indication.
`timescale 1ns/10ps
`include "mmce_defs.svh"
module mmce_exec (
    input wire logic clk,
    input wire logic rst,
    input wire logic q_en,
    input wire logic [15:0] instr,
    input wire logic instr_valid,
    input wire logic [15:0] pc,
    input wire logic [7:0] file_rdata,
    output logic [7:0] file_raddr,
    output logic [7:0] file_waddr,
    output logic [7:0] file_wdata,
    output logic file_we,
    output logic [15:0] stack_push_data,
    output logic stack_push,
    output logic [15:0] pc_load_value,
    output logic pc_load,
    output logic flush,
    output logic flag_inhibit,
    output logic [7:0] working_accumulator,
    output logic [7:0] bank_select_reg,
    output logic [7:0] counter_high_holding_latch,
    output logic [7:0] product_high_byte,
    output logic [7:0] product_low_byte,
    output logic busy
);
    // ****************************************
    // decode
    // ****************************************
    mmce_dec_if d ();
    mmce_decode u_dec (
        .instr(instr),
        .d(d)
    );

    logic [1:0] q_q;
    logic nop_q;
    mmce_pkg::mmce_op_t op_q;
    logic [15:0] word_q;
    logic [7:0] src_q;

    // ****************************************
    // q phase sequencing
    // ****************************************
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            q_q <= 2'h0;
        else if (q_en)
            q_q <= q_q + 2'h1;
    end

    wire q1 = q_en && (q_q == 2'h0);
    wire q2 = q_en && (q_q == 2'h1);
    wire q4 = q_en && (q_q == `MMCE_Q_LAST);

    // latch the word in Q1; a forced nop cycle ignores the fetched word
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            op_q <= mmce_pkg::MMCE_OP_NONE;
            word_q <= 16'h0000;
            nop_q <= 1'b0;
        end
        else if (q1)
        begin
            if (nop_q || !instr_valid)
                op_q <= mmce_pkg::MMCE_OP_NONE; // [RULE2]
            else
                op_q <= d.op;
            word_q <= instr;
            nop_q <= instr_valid && !nop_q && (d.op == mmce_pkg::MMCE_OP_CALL); // [RULE2]
        end
    end

    assign busy = nop_q;
    assign flush = nop_q; // [RULE2]

    // ****************************************
    // operand read, Q2
    // ****************************************
    function automatic logic [7:0] rd(input logic [7:0] a, input logic [7:0] acc,
                                      input logic [7:0] mem);
        return (a == `MMCE_ADDR_ACC) ? acc : mem; // [RULE6]
    endfunction : rd

    assign file_raddr = word_q[7:0];

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            src_q <= 8'h00;
        else if (q2)
            src_q <= rd(word_q[7:0], working_accumulator, file_rdata); // [RULE7]
    end

    // ****************************************
    // write back, Q4
    // ****************************************
    // operands widened first so the product keeps all 16 bits
    wire [15:0] lprod = {8'h00, word_q[7:0]} * {8'h00, working_accumulator}; // [RULE10]
    wire [15:0] rprod = {8'h00, src_q} * {8'h00, working_accumulator}; // [RULE12]

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            product_high_byte <= 8'h00;
            product_low_byte <= 8'h00;
        end
        else if (q4 && op_q == mmce_pkg::MMCE_OP_LMUL)
            {product_high_byte, product_low_byte} <= lprod; // [RULE10] [RULE14]
        else if (q4 && op_q == mmce_pkg::MMCE_OP_RMUL)
            {product_high_byte, product_low_byte} <= rprod; // [RULE12] [RULE14]
        else if (file_we && file_waddr == `MMCE_ADDR_PRODUCT_LOW_BYTE)
            product_low_byte <= file_wdata;
        else if (file_we && file_waddr == `MMCE_ADDR_PRODUCT_HIGH_BYTE)
            product_high_byte <= file_wdata;
    end

    wire move_wr = q4 && (op_q == mmce_pkg::MMCE_OP_MOVE);

    // move write to p, 0..31 only; flags untouched
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            file_we <= 1'b0;
            file_waddr <= 8'h00;
            file_wdata <= 8'h00;
        end
        else
        begin
            file_we <= move_wr; // [RULE7]
            if (move_wr)
            begin
                file_waddr <= {3'h0, word_q[12:8]}; // [RULE4]
                file_wdata <= src_q; // [RULE4]
            end
        end
    end

    // accumulator, latch and bank as move targets; bank load only touches 3:0
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            working_accumulator <= 8'h00;
            counter_high_holding_latch <= 8'h00;
            bank_select_reg <= 8'h00;
        end
        else if (move_wr)
        begin
            if ({3'h0, word_q[12:8]} == `MMCE_ADDR_ACC)
                working_accumulator <= src_q; // [RULE6]
            if ({3'h0, word_q[12:8]} == `MMCE_ADDR_CLATCH)
                counter_high_holding_latch <= src_q;
            if ({3'h0, word_q[12:8]} == `MMCE_ADDR_BANK)
                bank_select_reg <= src_q;
        end
        else if (q4 && op_q == mmce_pkg::MMCE_OP_BANK)
            bank_select_reg <= {bank_select_reg[7:4], word_q[3:0]}; // [RULE8] [RULE9]
    end

    // ****************************************
    // long call
    // ****************************************
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            stack_push <= 1'b0;
            stack_push_data <= 16'h0000;
            pc_load <= 1'b0;
            pc_load_value <= 16'h0000;
        end
        else
        begin
            // push in Q2, ahead of the Q4 redirect
            stack_push <= q2 && (op_q == mmce_pkg::MMCE_OP_CALL); // [RULE3]
            pc_load <= q4 && (op_q == mmce_pkg::MMCE_OP_CALL); // [RULE1]
            if (q2 && op_q == mmce_pkg::MMCE_OP_CALL)
                stack_push_data <= pc + 16'h0001; // [RULE3]
            if (q4 && op_q == mmce_pkg::MMCE_OP_CALL)
                pc_load_value <= {counter_high_holding_latch, word_q[7:0]}; // [RULE1]
        end
    end

    assign flag_inhibit = (op_q != mmce_pkg::MMCE_OP_NONE); // [RULE7] [RULE15]
endmodule : mmce_exec

/* File: test/mmce_exec_props.sv */
// checker for the move, multiply and call execute block
`timescale 1ns/10ps
// ****************
// port assertions
// ****************
module mmce_exec_props (
    input wire logic clk,
    input wire logic rst,
    input wire logic q_en,
    input wire logic [15:0] pc,
    input wire logic [7:0] file_waddr,
    input wire logic file_we,
    input wire logic [15:0] stack_push_data,
    input wire logic stack_push,
    input wire logic [15:0] pc_load_value,
    input wire logic pc_load,
    input wire logic flush,
    input wire logic busy,
    input wire logic [7:0] bank_select_reg,
    input wire logic [7:0] counter_high_holding_latch,
    input wire logic [7:0] product_high_byte,
    input wire logic [7:0] product_low_byte
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    chk_push_value: assert property (
        stack_push |-> stack_push_data == $past(pc) + 16'h1) else $error("bad return address");
    chk_load_high: assert property (
        pc_load |-> pc_load_value[15:8] == counter_high_holding_latch) else $error("bad high byte");
    chk_flush_follows: assert property (
        pc_load |-> ##[0:2] flush) else $error("no flush after call");
    chk_flush_busy: assert property (
        stack_push |-> busy && flush) else $error("call push without pending flush");
    chk_we_single: assert property (
        file_we |=> !file_we) else $error("write pulse too long");
    chk_we_range: assert property (
        file_we |-> file_waddr[7:5] == 3'h0) else $error("destination above 31");
    chk_prod_on_q: assert property (
        ($changed(product_low_byte) || $changed(product_high_byte)) |-> $past(q_en))
        else $error("product changed off a phase");
    chk_bank_upper: assert property (
        ($changed(bank_select_reg) && !(file_we && file_waddr == 8'h0f)) |->
        bank_select_reg[7:4] == $past(bank_select_reg[7:4]))
        else $error("bank upper nibble changed");
endmodule : mmce_exec_props
bind mmce_exec mmce_exec_props mmce_exec_props_i (.*);

/* File: test/move_multiply_call_exec_tb.sv */
// self-checking bench for the move, multiply and call execute block
`timescale 1ns/10ps
// ****************
// bench
// ****************
module move_multiply_call_exec_tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic q_en = 1'b1;
    logic instr_valid = 1'b1;
    logic [15:0] instr = 16'h0;
    logic [15:0] pc = 16'h0234;
    logic [7:0] mem [256];
    logic [7:0] file_raddr, file_waddr, file_wdata, wa, wd;
    logic [7:0] working_accumulator, bank_select_reg, counter_high_holding_latch;
    logic [7:0] product_high_byte, product_low_byte;
    logic [15:0] stack_push_data, pc_load_value;
    logic file_we, stack_push, pc_load, flush, busy, flag_inhibit;
    int err_total = 0;
    int check_count = 0;
    int cyc = 0;
    mmce_exec mmce_exec_i (.clk(clk), .rst(rst), .q_en(q_en), .instr(instr),
        .instr_valid(instr_valid), .pc(pc), .file_rdata(mem[file_raddr]),
        .file_raddr(file_raddr), .file_waddr(file_waddr), .file_wdata(file_wdata),
        .file_we(file_we), .stack_push_data(stack_push_data), .stack_push(stack_push),
        .pc_load_value(pc_load_value), .pc_load(pc_load), .flush(flush),
        .flag_inhibit(flag_inhibit),
        .working_accumulator(working_accumulator), .bank_select_reg(bank_select_reg),
        .counter_high_holding_latch(counter_high_holding_latch),
        .product_high_byte(product_high_byte), .product_low_byte(product_low_byte),
        .busy(busy));
    always #12.5 clk = ~clk;
    // write capture, since the write pulse lands inside the next instruction
    always @(posedge clk)
    begin
        cyc++;
        if (file_we)
        begin
            wa = file_waddr;
            wd = file_wdata;
        end
        if (cyc == 3000)
        begin
            err_total++;
            finish_test();
        end
    end
    task chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp)
        begin
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
            err_total++;
        end
    endtask : chk
    task run(input logic [15:0] w);
        instr = w;
        repeat (4) @(posedge clk);
        #1;
    endtask : run
    task t_move;
        mem[8'h40] = 8'he2;
        run({3'h3, 5'h0a, 8'h40});
        run(16'h0);
        chk(wa, 8'h0a);
        chk(wd, 8'he2);
        chk(working_accumulator, 8'he2);
        run({3'h3, 5'h1f, 8'h0a});
        run(16'h0);
        chk(wa, 8'h1f);
        chk(wd, 8'he2);
    endtask : t_move
    task t_mul;
        run(16'hbcc4);
        chk({product_high_byte, product_low_byte}, 16'had08);
        chk(flag_inhibit, 1'b1);
        mem[8'hb5] = 8'hb5;
        run(16'h34b5);
        chk({product_high_byte, product_low_byte}, 16'h9fca);
        chk(working_accumulator, 8'he2);
        run(16'h3420);
        chk({product_high_byte, product_low_byte}, 16'h0);
    endtask : t_mul
    // phases only advance on the enable pulse, so a gap must freeze the multiply
    task t_hold;
        instr = 16'hbc02;
        @(posedge clk);
        #1 q_en = 1'b0;
        repeat (3) @(posedge clk);
        #1;
        chk({product_high_byte, product_low_byte}, 16'h0000);
        q_en = 1'b1;
        repeat (3) @(posedge clk);
        #1;
        chk({product_high_byte, product_low_byte}, 16'h01c4);
    endtask : t_hold
    task t_bank;
        mem[8'h42] = 8'h5c;
        run({3'h3, 5'h0f, 8'h42});
        chk(bank_select_reg, 8'h5c);
        run(16'hb8f7);
        chk(bank_select_reg, 8'h57);
        run(16'hb80a);
        chk(bank_select_reg, 8'h5a);
    endtask : t_bank
    task t_call;
        mem[8'h41] = 8'h12;
        run({3'h3, 5'h03, 8'h41});
        instr = 16'hb799;
        repeat (2) @(posedge clk);
        #1;
        chk(busy, 1'b1);
        chk(stack_push, 1'b1);
        repeat (2) @(posedge clk);
        #1;
        chk(pc_load, 1'b1);
        // the word fetched behind the call must be dropped
        run(16'hb805);
        chk(busy, 1'b0);
        chk(stack_push_data, 16'h0235);
        chk(pc_load_value, 16'h1299);
        chk(bank_select_reg, 8'h5a);
        run(16'h0);
        chk(busy, 1'b0);
        chk(flag_inhibit, 1'b0);
    endtask : t_call
    task finish_test;
        if (err_total == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : finish_test
    initial
    begin
        foreach (mem[i]) mem[i] = 8'h00;
        repeat (2) @(posedge clk);
        #1 rst = 1'b0;
        t_move();
        t_mul();
        t_hold();
        t_bank();
        t_call();
        finish_test();
    end
endmodule : move_multiply_call_exec_tb
